// ### rtl/pfpc_pin_ctrl.sv
// Pin function multiplexer, pull control and debug/mode-select pin handling
//
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pfpc_regs.svh"

module pfpc_pin_ctrl (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // AXI4-Lite write address
   input wire logic [`PFPC_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [`PFPC_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // General-purpose pins
   input wire logic [`PFPC_NUM_PINS-1:0] gp_pin_in,
   output logic [`PFPC_NUM_PINS-1:0] gp_pin_out,
   output logic [`PFPC_NUM_PINS-1:0] gp_pin_oe,
   output logic [`PFPC_NUM_PINS-1:0] gp_pull_up_en,
   output logic [`PFPC_NUM_PINS-1:0] gp_pull_down_en,
   // Peripheral ownership
   input wire logic [`PFPC_NUM_PINS-1:0] periph_sel,
   input wire logic [`PFPC_NUM_PINS-1:0] periph_out,
   input wire logic [`PFPC_NUM_PINS-1:0] periph_oe,
   output logic [`PFPC_NUM_PINS-1:0] periph_in,
   // Keypad sensitivity of port_a_upper_nibble
   input wire logic [3:0] keypad_rising_sense,
   // External interrupt pin
   input wire logic ext_int_pin_in,
   output logic ext_int_pull_up_en,
   output logic ext_int_pull_down_en,
   output logic ext_int_level,
   // Shared debug / mode select pin
   input wire logic dbg_pin_in,
   output logic dbg_pin_out,
   output logic dbg_pin_oe,
   output logic dbg_pull_up_en,
   // Background debug controller side
   input wire logic bdc_drive_low,
   input wire logic bdc_speedup,
   output logic debug_line_in,
   output logic bdc_bit_tick,
   output logic boot_background
);

   // ----------------------------------------
   // Helper functions
   // ----------------------------------------
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                               input logic [31:0] new_val,
                                               input logic [3:0] strb);
      logic [31:0] res;
      res = old_val;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = new_val[b*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic [31:0] hi_word(input logic [`PFPC_NUM_PINS-1:0] v);
      return {28'h0000000, v[`PFPC_NUM_PINS-1:32]};
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   pfpc_pkg::pfpc_boot_t boot_state, next_boot_state;
   logic [31:0] ctrl, next_ctrl;
   logic [`PFPC_NUM_PINS-1:0] port_data, next_port_data;
   logic [`PFPC_NUM_PINS-1:0] port_dir, next_port_dir;
   logic [`PFPC_NUM_PINS-1:0] pull_en, next_pull_en;
   logic aw_held, next_aw_held;
   logic [`PFPC_ADDR_W-1:0] aw_addr, next_aw_addr;
   logic w_held, next_w_held;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic bvalid, next_bvalid;
   logic [1:0] bresp, next_bresp;
   logic rvalid, next_rvalid;
   logic [1:0] rresp, next_rresp;
   logic [31:0] rdata, next_rdata;
   logic dbg_prev, next_dbg_prev;
   logic slot_active, next_slot_active;
   logic [3:0] slot_cnt, next_slot_cnt;
   logic bit_tick, next_bit_tick;
   logic [`PFPC_NUM_PINS-1:0] port_read;
   logic out_mode;
   logic link_live;

   // ----------------------------------------
   // Boot mode capture
   // ----------------------------------------
   // Flop resets to a constant; the pin is sampled at the first edge after release
   always_comb begin
      next_boot_state = boot_state;
      case (boot_state)
         pfpc_pkg::BOOT_IN_RESET: begin
            if (dbg_pin_in) begin
               next_boot_state = pfpc_pkg::BOOT_NORMAL;
            end else begin
               next_boot_state = pfpc_pkg::BOOT_BACKGROUND;
            end
         end
         pfpc_pkg::BOOT_NORMAL: next_boot_state = pfpc_pkg::BOOT_NORMAL;
         pfpc_pkg::BOOT_BACKGROUND: next_boot_state = pfpc_pkg::BOOT_BACKGROUND;
         default: next_boot_state = pfpc_pkg::BOOT_IN_RESET;
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         boot_state <= pfpc_pkg::BOOT_IN_RESET;
      end else begin
         boot_state <= next_boot_state;
      end
   end

   assign boot_background = (boot_state == pfpc_pkg::BOOT_BACKGROUND);
   assign link_live = (boot_state != pfpc_pkg::BOOT_IN_RESET);
   assign out_mode = ctrl[`PFPC_CTRL_PGB0_OUT_MODE] & link_live;

   // ----------------------------------------
   // Shared debug pin
   // ----------------------------------------
   // No drive at all until the mode level is caught
   always_comb begin
      dbg_pin_out = 1'b0;
      dbg_pin_oe = 1'b0;
      dbg_pull_up_en = 1'b1;
      if (out_mode) begin
         dbg_pin_out = ctrl[`PFPC_CTRL_PGB0_DATA];
         dbg_pin_oe = 1'b1;
         dbg_pull_up_en = 1'b0;
      end else if (link_live) begin
         // Low drive or speedup pulse, otherwise released to the pullup
         dbg_pin_out = bdc_speedup & ~bdc_drive_low;
         dbg_pin_oe = bdc_drive_low | bdc_speedup;
      end
   end

   assign debug_line_in = link_live & ~out_mode & dbg_pin_in;

   // ----------------------------------------
   // Debug bit slot timer
   // ----------------------------------------
   // A falling edge from either side opens a slot of fixed length
   always_comb begin
      next_dbg_prev = debug_line_in;
      next_slot_active = slot_active;
      next_slot_cnt = slot_cnt;
      next_bit_tick = 1'b0;
      if (dbg_prev && !debug_line_in && link_live && !out_mode && !slot_active) begin
         next_slot_active = 1'b1;
         next_slot_cnt = 4'h0;
      end else if (slot_active) begin
         next_slot_cnt = slot_cnt + 4'h1;
         if (slot_cnt == 4'(`PFPC_BIT_CYCLES - 1)) begin
            next_slot_active = 1'b0;
            next_bit_tick = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         dbg_prev <= 1'b1;
         slot_active <= 1'b0;
         slot_cnt <= 4'h0;
         bit_tick <= 1'b0;
      end else begin
         dbg_prev <= next_dbg_prev;
         slot_active <= next_slot_active;
         slot_cnt <= next_slot_cnt;
         bit_tick <= next_bit_tick;
      end
   end

   assign bdc_bit_tick = bit_tick;

   // ----------------------------------------
   // External interrupt pin
   // ----------------------------------------
   assign ext_int_level = ctrl[`PFPC_CTRL_EXT_INT_EN] & ext_int_pin_in;
   assign ext_int_pull_up_en = ctrl[`PFPC_CTRL_EXT_INT_EN] & ~ctrl[`PFPC_CTRL_EXT_INT_RISE];
   assign ext_int_pull_down_en = ctrl[`PFPC_CTRL_EXT_INT_EN] & ctrl[`PFPC_CTRL_EXT_INT_RISE];

   // ----------------------------------------
   // General-purpose pin multiplexer
   // ----------------------------------------
   for (genvar i = 0; i < `PFPC_NUM_PINS; i++) begin : g_pin
      logic as_input;
      logic pull_down_sel;
      assign gp_pin_out[i] = periph_sel[i] ? periph_out[i] : port_data[i];
      assign gp_pin_oe[i] = periph_sel[i] ? periph_oe[i] : port_dir[i];
      assign as_input = ~gp_pin_oe[i];
      assign periph_in[i] = gp_pin_in[i];
      // Direction bit, not the owner, picks what a port read returns
      assign port_read[i] = port_dir[i] ? port_data[i] : gp_pin_in[i];
      if (i >= 4 && i <= 7) begin : g_kpi
         assign pull_down_sel = periph_sel[i] & keypad_rising_sense[i-4];
      end else begin : g_plain
         assign pull_down_sel = 1'b0;
      end
      assign gp_pull_up_en[i] = pull_en[i] & as_input & ~pull_down_sel;
      assign gp_pull_down_en[i] = pull_en[i] & as_input & pull_down_sel;
   end

   // ----------------------------------------
   // AXI4-Lite register slave
   // ----------------------------------------
   assign s_axi_awready = ~aw_held & ~bvalid;
   assign s_axi_wready = ~w_held & ~bvalid;
   assign s_axi_arready = ~rvalid;
   assign s_axi_bvalid = bvalid;
   assign s_axi_bresp = bresp;
   assign s_axi_rvalid = rvalid;
   assign s_axi_rresp = rresp;
   assign s_axi_rdata = rdata;

   always_comb begin
      next_ctrl = ctrl;
      next_port_data = port_data;
      next_port_dir = port_dir;
      next_pull_en = pull_en;
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held = w_held;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rresp = rresp;
      next_rdata = rdata;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      // Commit only once both halves are held
      if (aw_held && w_held) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = `PFPC_RESP_OKAY;
         case (aw_addr)
            `PFPC_OFS_CTRL: next_ctrl = merge_bytes(ctrl, w_data, w_strb) & `PFPC_CTRL_MASK;
            `PFPC_OFS_DATA_LO: next_port_data[31:0] = merge_bytes(port_data[31:0], w_data, w_strb);
            `PFPC_OFS_DATA_HI: next_port_data[35:32] = w_strb[0] ? w_data[3:0] : port_data[35:32];
            `PFPC_OFS_DIR_LO: next_port_dir[31:0] = merge_bytes(port_dir[31:0], w_data, w_strb);
            `PFPC_OFS_DIR_HI: next_port_dir[35:32] = w_strb[0] ? w_data[3:0] : port_dir[35:32];
            `PFPC_OFS_PULL_LO: next_pull_en[31:0] = merge_bytes(pull_en[31:0], w_data, w_strb);
            `PFPC_OFS_PULL_HI: next_pull_en[35:32] = w_strb[0] ? w_data[3:0] : pull_en[35:32];
            `PFPC_OFS_STATUS, `PFPC_OFS_PORT_LO, `PFPC_OFS_PORT_HI: begin
            end
            default: next_bresp = `PFPC_RESP_SLVERR;
         endcase
      end
      if (rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp = `PFPC_RESP_OKAY;
         case (s_axi_araddr)
            `PFPC_OFS_CTRL: next_rdata = ctrl;
            `PFPC_OFS_STATUS: next_rdata = {30'h00000000, debug_line_in, boot_background};
            `PFPC_OFS_DATA_LO: next_rdata = port_data[31:0];
            `PFPC_OFS_DATA_HI: next_rdata = hi_word(port_data);
            `PFPC_OFS_DIR_LO: next_rdata = port_dir[31:0];
            `PFPC_OFS_DIR_HI: next_rdata = hi_word(port_dir);
            `PFPC_OFS_PULL_LO: next_rdata = pull_en[31:0];
            `PFPC_OFS_PULL_HI: next_rdata = hi_word(pull_en);
            `PFPC_OFS_PORT_LO: next_rdata = port_read[31:0];
            `PFPC_OFS_PORT_HI: next_rdata = hi_word(port_read);
            default: begin
               next_rdata = 32'h00000000;
               next_rresp = `PFPC_RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ctrl <= `PFPC_CTRL_RST;
         port_data <= `PFPC_VEC_RST;
         port_dir <= `PFPC_VEC_RST;
         pull_en <= `PFPC_VEC_RST;
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
         w_held <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         bvalid <= 1'b0;
         bresp <= 2'h0;
         rvalid <= 1'b0;
         rresp <= 2'h0;
         rdata <= 32'h00000000;
      end else begin
         ctrl <= next_ctrl;
         port_data <= next_port_data;
         port_dir <= next_port_dir;
         pull_en <= next_pull_en;
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held <= next_w_held;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
      end
   end

endmodule

// ### pkg/pfpc_regs.svh
// Register offsets, field positions, reset values and timing counts of the pin controller
`ifndef PFPC_REGS_SVH
`define PFPC_REGS_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define PFPC_NUM_PINS 36
`define PFPC_ADDR_W 8

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PFPC_OFS_CTRL 8'h00
`define PFPC_OFS_STATUS 8'h04
`define PFPC_OFS_DATA_LO 8'h08
`define PFPC_OFS_DATA_HI 8'h0c
`define PFPC_OFS_DIR_LO 8'h10
`define PFPC_OFS_DIR_HI 8'h14
`define PFPC_OFS_PULL_LO 8'h18
`define PFPC_OFS_PULL_HI 8'h1c
`define PFPC_OFS_PORT_LO 8'h20
`define PFPC_OFS_PORT_HI 8'h24

// ----------------------------------------
// Control fields
// ----------------------------------------
`define PFPC_CTRL_EXT_INT_EN 0
`define PFPC_CTRL_EXT_INT_RISE 1
`define PFPC_CTRL_PGB0_OUT_MODE 2
`define PFPC_CTRL_PGB0_DATA 3
`define PFPC_CTRL_MASK 32'h0000000f

// ----------------------------------------
// Status fields
// ----------------------------------------
`define PFPC_STAT_BACKGROUND 0
`define PFPC_STAT_DEBUG_LINE 1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PFPC_CTRL_RST 32'h00000000
`define PFPC_VEC_RST 36'h000000000

// ----------------------------------------
// Timing and responses
// ----------------------------------------
`define PFPC_BIT_CYCLES 16
`define PFPC_RESP_OKAY 2'h0
`define PFPC_RESP_SLVERR 2'h2

`endif

// ### pkg/pfpc_pkg.sv
// Types shared by the pin function and pull controller
package pfpc_pkg;

   // Boot mode chosen at reset release
   typedef enum logic [1:0] {
      BOOT_IN_RESET,
      BOOT_NORMAL,
      BOOT_BACKGROUND
   } pfpc_boot_t;

endpackage

// ### dv/pfpc_pin_ctrl_checker.sv
// Port-level assertions for the pin function and pull controller
`timescale 1ns/1ps
`include "pfpc_regs.svh"
module pfpc_pin_ctrl_checker (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // General-purpose pins
   input wire logic [`PFPC_NUM_PINS-1:0] gp_pin_in,
   input wire logic [`PFPC_NUM_PINS-1:0] gp_pin_out,
   input wire logic [`PFPC_NUM_PINS-1:0] gp_pin_oe,
   input wire logic [`PFPC_NUM_PINS-1:0] gp_pull_up_en,
   input wire logic [`PFPC_NUM_PINS-1:0] gp_pull_down_en,
   input wire logic [`PFPC_NUM_PINS-1:0] periph_sel,
   input wire logic [`PFPC_NUM_PINS-1:0] periph_out,
   input wire logic [`PFPC_NUM_PINS-1:0] periph_oe,
   input wire logic [`PFPC_NUM_PINS-1:0] periph_in,
   input wire logic [3:0] keypad_rising_sense,
   // External interrupt pin
   input wire logic ext_int_pin_in,
   input wire logic ext_int_pull_up_en,
   input wire logic ext_int_pull_down_en,
   input wire logic ext_int_level,
   // Debug pin
   input wire logic dbg_pin_in,
   input wire logic dbg_pin_out,
   input wire logic dbg_pin_oe,
   input wire logic dbg_pull_up_en,
   input wire logic bdc_drive_low,
   input wire logic bdc_speedup,
   input wire logic debug_line_in,
   input wire logic bdc_bit_tick,
   input wire logic boot_background
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   chk_reset_state: assert property (
      $rose(arst_n) |-> !dbg_pin_oe && dbg_pull_up_en && !boot_background && !(|{gp_pull_up_en,
      gp_pull_down_en, ext_int_level, ext_int_pull_up_en, ext_int_pull_down_en}))
      else $error("reset state wrong");
   chk_boot_capture: assert property (
      $rose(arst_n) |=> boot_background == !$past(dbg_pin_in)) else $error("boot mode wrong");
   chk_boot_held: assert property (
      $past(arst_n, 2) |-> $stable(boot_background)) else $error("boot mode changed");
   chk_dbg_pullup: assert property (
      !dbg_pin_oe |-> dbg_pull_up_en) else $error("debug pullup off");
   chk_line_low: assert property (
      bdc_drive_low && dbg_pull_up_en |-> dbg_pin_oe && !dbg_pin_out && !debug_line_in)
      else $error("debug line not low");
   chk_speedup_high: assert property (
      bdc_speedup && !bdc_drive_low && dbg_pull_up_en |-> dbg_pin_oe && dbg_pin_out)
      else $error("speedup not driven");
   chk_bit_slot: assert property (
      bdc_bit_tick && $past(arst_n, 18) |-> !$past(debug_line_in, 17) && $past(debug_line_in, 18))
      else $error("bit tick misplaced");
   chk_ext_int: assert property (
      ext_int_level |-> ext_int_pin_in && (ext_int_pull_up_en ^ ext_int_pull_down_en))
      else $error("ext int level wrong");
   chk_periph_prio: assert property (
      ((gp_pin_oe ^ periph_oe) & periph_sel) == 0
      && ((gp_pin_out ^ periph_out) & periph_sel & periph_oe) == 0) else $error("mux wrong");
   chk_pull_input: assert property (
      ((gp_pull_up_en | gp_pull_down_en) & gp_pin_oe) == 0 && (gp_pull_up_en & gp_pull_down_en) == 0
      && (gp_pull_down_en & ~{28'h0, periph_sel[7:4] & keypad_rising_sense, 4'h0}) == 0)
      else $error("pull wrong");
   chk_periph_in: assert property (
      periph_in == gp_pin_in) else $error("periph input wrong");
   cover property ($rose(arst_n) ##1 boot_background);
   cover property (bdc_bit_tick);
   cover property (ext_int_pull_down_en);
   cover property (|gp_pull_down_en);
endmodule
bind pfpc_pin_ctrl pfpc_pin_ctrl_checker i_pfpc_pin_ctrl_checker (.*);

// ### dv/pfpc_dbg_host.sv
// Debug host and pin load model on the shared debug pin
`timescale 1ns/1ps
module pfpc_dbg_host (
   // Clock
   input wire logic clk_sys,
   // Host control
   input wire logic hold_low,
   // Device side and resolved level
   input wire logic dbg_pin_oe,
   input wire logic dbg_pin_out,
   input wire logic dbg_pull_up_en,
   output logic line
);
   logic last = 1'b1;
   // Unpulled and released: keep changing so a stale level never passes
   always_comb begin
      if (dbg_pin_oe) line = dbg_pin_out;
      else if (hold_low) line = 1'b0;
      else if (dbg_pull_up_en) line = 1'b1;
      else line = ~last;
   end
   always_ff @(posedge clk_sys) last <= line;
endmodule

// ### dv/tb_pfpc_pin_ctrl.sv
// Self-checking testbench of the pin function and pull controller
`timescale 1ns/1ps
`include "pfpc_regs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((e) !== (g)) begin n_mismatch++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_pfpc_pin_ctrl;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic hold = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, seed = 32'h93b8, dir, dat, ex;
   logic [3:0] s_axi_wstrb = 4'hf, keypad_rising_sense = 4'h0;
   logic [35:0] gp_pin_in = 36'h0, periph_sel = 36'h0, periph_out = 36'h0, periph_oe = 36'h0;
   logic ext_int_pin_in = 1'b1, bdc_drive_low = 1'b0, bdc_speedup = 1'b0;
   wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire logic [1:0] s_axi_bresp, s_axi_rresp;
   wire logic [31:0] s_axi_rdata;
   wire logic [35:0] gp_pin_out, gp_pin_oe, gp_pull_up_en, gp_pull_down_en, periph_in;
   wire logic ext_int_pull_up_en, ext_int_pull_down_en, ext_int_level, dbg_pin_in, dbg_pin_out;
   wire logic dbg_pin_oe, dbg_pull_up_en, debug_line_in, bdc_bit_tick, boot_background;
   int n_tests = 0, n_mismatch = 0, i, k;
   logic [34:0] q[$];
   logic [34:0] e;
   always #5 clk_sys = ~clk_sys;
   pfpc_pin_ctrl i_pfpc_pin_ctrl (.*);
   pfpc_dbg_host i_pfpc_dbg_host (.clk_sys, .hold_low(hold), .dbg_pin_oe, .dbg_pin_out,
      .dbg_pull_up_en, .line(dbg_pin_in));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic give_verdict();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic do_reset(input logic low);
      @(posedge clk_sys);
      arst_n <= 1'b0;
      hold <= low;
      repeat (16) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      hold <= 1'b0;
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      q.push_back({1'b0, r, 32'h0});
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (k = 0; k < 64; k++) begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (k == 64) begin n_mismatch++; give_verdict(); end
   endtask
   task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      q.push_back({1'b1, r, d});
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (k = 0; k < 64; k++) begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      if (k == 64) begin n_mismatch++; give_verdict(); end
   endtask
   // Watcher pairs each bus answer with the oldest note
   always @(posedge clk_sys) begin
      if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
         e = (q.size() > 0) ? q.pop_front() : 35'h0;
         `CHK("resp", e[33:32], e[34] ? s_axi_rresp : s_axi_bresp)
         if (e[34]) `CHK("rdata", e[31:0], s_axi_rdata)
      end
   end
   initial begin
      do_reset(1'b0);
      @(negedge clk_sys);
      `CHK("boot", 1'b0, boot_background)
      `CHK("rst_pull", 72'h0, {gp_pull_up_en, gp_pull_down_en})
      `CHK("rst_oe", 36'h0, gp_pin_oe)
      `CHK("rst_eint", 3'h0, {ext_int_pull_up_en, ext_int_pull_down_en, ext_int_level})
      axr(`PFPC_OFS_STATUS, 32'h2, `PFPC_RESP_OKAY);
      axr(`PFPC_OFS_CTRL, `PFPC_CTRL_RST, `PFPC_RESP_OKAY);
      $display("test boot_normal done");
      for (i = 0; i < 4; i++) begin
         @(posedge clk_sys);
         seed = lfsr(seed);
         dir = seed;
         seed = lfsr(seed);
         dat = seed;
         seed = lfsr(seed);
         gp_pin_in <= {dat[7:4], seed};
         periph_sel <= {4'h0, dir ^ seed};
         periph_oe <= {4'h0, ~seed};
         periph_out <= {4'h0, dat ^ dir};
         axw(`PFPC_OFS_DIR_LO, dir, `PFPC_RESP_OKAY);
         axw(`PFPC_OFS_DATA_LO, dat, `PFPC_RESP_OKAY);
         axw(`PFPC_OFS_PULL_LO, 32'hffffffff, `PFPC_RESP_OKAY);
         axw(`PFPC_OFS_DIR_HI, {28'h0, dir[3:0]}, `PFPC_RESP_OKAY);
         axw(`PFPC_OFS_DATA_HI, {28'h0, dat[3:0]}, `PFPC_RESP_OKAY);
         axr(`PFPC_OFS_PORT_LO, (dir & dat) | (~dir & seed), `PFPC_RESP_OKAY);
         ex = {28'h0, (dir[3:0] & dat[3:0]) | (~dir[3:0] & dat[7:4])};
         axr(`PFPC_OFS_PORT_HI, ex, `PFPC_RESP_OKAY);
         @(negedge clk_sys);
         ex = (periph_sel[31:0] & periph_oe[31:0]) | (~periph_sel[31:0] & dir);
         `CHK("oe", ex, gp_pin_oe[31:0])
         `CHK("out", ((periph_sel[31:0] & periph_out[31:0]) | (~periph_sel[31:0] & dat)) & ex,
            gp_pin_out[31:0] & ex)
         `CHK("pull", ~ex, gp_pull_up_en[31:0])
         `CHK("pin_in", gp_pin_in, periph_in)
      end
      $display("test port_mux done");
      @(posedge clk_sys);
      periph_sel <= 36'hf0;
      periph_oe <= 36'h0;
      keypad_rising_sense <= 4'ha;
      axw(`PFPC_OFS_DIR_LO, 32'h0, `PFPC_RESP_OKAY);
      @(negedge clk_sys);
      `CHK("kbd_down", 36'ha0, gp_pull_down_en)
      `CHK("kbd_up", 8'h5f, gp_pull_up_en[7:0])
      // Partial strobe clears only byte one of the pull enables
      @(posedge clk_sys);
      s_axi_wstrb <= 4'h2;
      axw(`PFPC_OFS_PULL_LO, 32'h0, `PFPC_RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      axr(`PFPC_OFS_PULL_LO, 32'hffff00ff, `PFPC_RESP_OKAY);
      axw(`PFPC_OFS_PULL_HI, 32'hffffffff, `PFPC_RESP_OKAY);
      axr(`PFPC_OFS_PULL_HI, 32'hf, `PFPC_RESP_OKAY);
      $display("test keypad_pull done");
      for (i = 0; i < 4; i++) begin
         @(posedge clk_sys);
         ext_int_pin_in <= ~ext_int_pin_in;
         axw(`PFPC_OFS_CTRL, i, `PFPC_RESP_OKAY);
         @(negedge clk_sys);
         `CHK("eint", {i[0] & !i[1], i[0] & i[1], i[0] & ext_int_pin_in},
            {ext_int_pull_up_en, ext_int_pull_down_en, ext_int_level})
      end
      $display("test ext_int done");
      for (i = 0; i < 2; i++) begin
         axw(`PFPC_OFS_CTRL, 32'h4 | (i << 3), `PFPC_RESP_OKAY);
         @(negedge clk_sys);
         `CHK("pg0", {2'b10, i[0]}, {dbg_pin_oe, dbg_pull_up_en, dbg_pin_out})
         axr(`PFPC_OFS_STATUS, 32'h0, `PFPC_RESP_OKAY);
      end
      axw(`PFPC_OFS_CTRL, 32'h0, `PFPC_RESP_OKAY);
      axw(8'h40, 32'h1, `PFPC_RESP_SLVERR);
      axr(8'h40, 32'h0, `PFPC_RESP_SLVERR);
      axw(`PFPC_OFS_STATUS, 32'hffffffff, `PFPC_RESP_OKAY);
      axr(`PFPC_OFS_STATUS, 32'h2, `PFPC_RESP_OKAY);
      $display("test port_g_and_map done");
      bdc_drive_low <= 1'b1;
      @(negedge clk_sys);
      `CHK("drv", 4'ha, {dbg_pin_oe, dbg_pin_out, dbg_pull_up_en, debug_line_in})
      for (k = 1; k < 40; k++) begin
         @(posedge clk_sys);
         bdc_drive_low <= 1'b0;
         bdc_speedup <= (k == 1);
         if (bdc_bit_tick) break;
      end
      `CHK("slot", 18, k)
      $display("test bit_slot done");
      do_reset(1'b1);
      axr(`PFPC_OFS_STATUS, 32'h3, `PFPC_RESP_OKAY);
      `CHK("boot", 1'b1, boot_background)
      hold <= 1'b1;
      axr(`PFPC_OFS_STATUS, 32'h1, `PFPC_RESP_OKAY);
      hold <= 1'b0;
      $display("test boot_background done");
      give_verdict();
   end
endmodule
